/* File: hdl/mfc_pkg.sv */
// Package with field positions, reset values and state types of the feature-control bits.
package mfc_pkg;
   localparam int unsigned MFC_W = 9;
   localparam int unsigned MFC_LSB = 4;
   // Field positions inside the 9-bit slice (bits 12:4 of the feature register).
   localparam int unsigned MFC_SPLIT_DIS = 0;
   localparam int unsigned MFC_RSVD5 = 1;
   localparam int unsigned MFC_L3_DIS = 2;
   localparam int unsigned MFC_PERF_AVAIL = 3;
   localparam int unsigned MFC_LOCK_SUPP = 4;
   localparam int unsigned MFC_PFQ_DIS = 5;
   localparam int unsigned MFC_FPE_IRQ_EN = 6;
   localparam int unsigned MFC_BTS_ABSENT = 7;
   localparam int unsigned MFC_PRECISE_EVENT_SAMPLING_ABSENT = 8;
   // Mask of the writable bits; bit 2 joins only when the cache is fitted.
   localparam logic [8:0] MFC_WR_MASK_BASE = 9'h071;
   localparam logic [8:0] MFC_WR_MASK_L3 = 9'h004;
   localparam logic [8:0] MFC_RESET = 9'h000;
   typedef enum logic [1:0] {MFC_RUN, MFC_STOPPED, MFC_WAKE} mfc_clk_state_e;
endpackage

/* File: hdl/mfc_sync.sv */
// Two-flip-flop synchroniser for one level input.
module mfc_sync
   import mfc_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Level in and out.
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule

/* File: hdl/mfc_ctrl.sv */
// Feature-control bits 12:4 with their effects on lock, cache, prefetch and fp error pin.
module mfc_ctrl
   import mfc_pkg::*;
#(
   parameter logic L3_PRESENT = 1'b1,
   parameter logic PERF_MON_EN = 1'b1,
   parameter logic BTS_SUPPORTED = 1'b1,
   parameter logic PRECISE_EVENT_SAMPLING_SUPPORTED = 1'b1
) (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Feature register access, slice of bits 12:4.
   input wire logic wr_en_i,
   input wire logic [8:0] wr_data_i,
   output logic [8:0] rd_data_o,
   // Locked access requests from the core.
   input wire logic split_lock_req_i,
   output logic alignment_check_fault_o,
   output logic split_lock_cycle_o,
   output logic bus_lock_o,
   // Cache and prefetch.
   input wire logic global_cache_disable_flag_i,
   input wire logic page_cache_en_i,
   input wire logic memory_type_ranges_cache_en_i,
   output logic l3_cache_en_o,
   output logic prefetch_queue_en_o,
   // Floating-point error pin and stop clock, both from pins.
   input wire logic unmasked_fp_error_i,
   input wire logic stop_clock_input_n_i,
   input wire logic fp_error_pin_n_i,
   output logic fp_error_pin_n_o,
   output logic fp_error_pin_oe_o,
   output logic stop_clock_state_o,
   output logic wake_irq_o
);
   logic [8:0] ctrl_q;
   logic [8:0] ctrl_d;
   logic [8:0] rd_q;
   logic [8:0] rd_d;
   logic [8:0] wr_mask;
   logic stop_s;
   logic fpe_s;
   mfc_clk_state_e st_q;
   mfc_clk_state_e st_d;
   logic fault_q;
   logic fault_d;
   logic cyc_q;
   logic cyc_d;
   logic lock_q;
   logic lock_d;
   logic l3_q;
   logic l3_d;
   logic pfq_q;
   logic pfq_d;
   logic fp_error_pin_q;
   logic fp_error_pin_d;
   logic oe_q;
   logic oe_d;
   logic stop_q;
   logic stop_d;
   logic wake_q;
   logic wake_d;

   mfc_sync #(.RST_VAL(1'b1)) u_sync_stop (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .async_i(stop_clock_input_n_i),
      .sync_o(stop_s)
   );
   mfc_sync #(.RST_VAL(1'b1)) u_sync_fpe (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .async_i(fp_error_pin_n_i),
      .sync_o(fpe_s)
   );

   always_comb begin
      wr_mask = MFC_WR_MASK_BASE | (L3_PRESENT ? MFC_WR_MASK_L3 : MFC_RESET);
      ctrl_d = ctrl_q;
      if (wr_en_i) begin
         ctrl_d = wr_data_i & wr_mask;
      end
      rd_d = ctrl_d;
      rd_d[MFC_PERF_AVAIL] = PERF_MON_EN;
      rd_d[MFC_BTS_ABSENT] = ~BTS_SUPPORTED;
      rd_d[MFC_PRECISE_EVENT_SAMPLING_ABSENT] = ~PRECISE_EVENT_SAMPLING_SUPPORTED;
   end

   // Split-lock requests become either a fault or a bus cycle with optional lock.
   always_comb begin
      fault_d = split_lock_req_i & ctrl_q[MFC_SPLIT_DIS];
      cyc_d = split_lock_req_i & ~ctrl_q[MFC_SPLIT_DIS];
      lock_d = cyc_d & ~ctrl_q[MFC_LOCK_SUPP];
   end

   // Cache and prefetch enables.
   always_comb begin
      l3_d = L3_PRESENT & ~ctrl_q[MFC_L3_DIS] & ~global_cache_disable_flag_i
         & page_cache_en_i & memory_type_ranges_cache_en_i;
      pfq_d = ~ctrl_q[MFC_PFQ_DIS];
   end

   // Stop clock state and wake through the fp error pin.
   always_comb begin
      st_d = st_q;
      wake_d = 1'b0;
      unique case (st_q)
         MFC_RUN: begin
            if (!stop_s) begin
               st_d = MFC_STOPPED;
            end
         end
         MFC_STOPPED: begin
            if (stop_s) begin
               st_d = MFC_RUN;
            end else if (ctrl_q[MFC_FPE_IRQ_EN] && !fpe_s) begin
               st_d = MFC_WAKE;
               wake_d = 1'b1;
            end
         end
         MFC_WAKE: begin
            if (stop_s) begin
               st_d = MFC_RUN;
            end
         end
      endcase
      stop_d = (st_d == MFC_STOPPED);
   end

   // Pin reports fp errors only while running; in stop clock it is an input.
   always_comb begin
      oe_d = stop_s;
      fp_error_pin_d = ~(stop_s & unmasked_fp_error_i);
   end

   // Control slice and its read value.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= MFC_RESET;
         rd_q <= MFC_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         rd_q <= rd_d;
      end
   end

   // Split-lock outputs.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fault_q <= 1'b0;
         cyc_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
         cyc_q <= cyc_d;
         lock_q <= lock_d;
      end
   end

   // Cache and prefetch outputs.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         l3_q <= 1'b0;
         pfq_q <= 1'b1;
      end else begin
         l3_q <= l3_d;
         pfq_q <= pfq_d;
      end
   end

   // Stop clock state machine and its outputs.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= MFC_RUN;
         stop_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         st_q <= st_d;
         stop_q <= stop_d;
         wake_q <= wake_d;
      end
   end

   // Fp error pin driver.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fp_error_pin_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         fp_error_pin_q <= fp_error_pin_d;
         oe_q <= oe_d;
      end
   end

   assign rd_data_o = rd_q;
   assign alignment_check_fault_o = fault_q;
   assign split_lock_cycle_o = cyc_q;
   assign bus_lock_o = lock_q;
   assign l3_cache_en_o = l3_q;
   assign prefetch_queue_en_o = pfq_q;
   assign fp_error_pin_n_o = fp_error_pin_q;
   assign fp_error_pin_oe_o = oe_q;
   assign stop_clock_state_o = stop_q;
   assign wake_irq_o = wake_q;
endmodule

/* File: verif/mfc_ctrl_checker.sv */
// Assertions on the feature-control bits.
module mfc_ctrl_checker (
   input wire logic clk_sys_i, nrst_i, wr_en_i, split_lock_req_i, fp_error_pin_n_i,
   input wire logic [8:0] wr_data_i, rd_data_o,
   input wire logic alignment_check_fault_o, split_lock_cycle_o, bus_lock_o,
   input wire logic prefetch_queue_en_o, stop_clock_state_o, wake_irq_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   fault_taken_a: assert property (split_lock_req_i && rd_data_o[0]
      |=> alignment_check_fault_o && !split_lock_cycle_o) else $error("no fault");
   plain_cycle_a: assert property (split_lock_req_i && !rd_data_o[0]
      |=> split_lock_cycle_o && !alignment_check_fault_o) else $error("no cycle");
   lock_supp_a: assert property (split_lock_req_i && !rd_data_o[0]
      |=> bus_lock_o != $past(rd_data_o[4])) else $error("bad lock");
   pfq_level_a: assert property (prefetch_queue_en_o == !$past(rd_data_o[5]))
      else $error("bad prefetch");
   const_bits_a: assert property ($past(nrst_i)
      |-> (rd_data_o & 9'h18a) == 9'h008) else $error("bad constant bits");
   write_take_a: assert property (wr_en_i
      |=> (rd_data_o & 9'h075) == ($past(wr_data_i) & 9'h075)) else $error("write lost");
   rd_hold_a: assert property (!wr_en_i && $past(nrst_i) |=> $stable(rd_data_o))
      else $error("read value moved");
   wake_time_a: assert property (stop_clock_state_o && rd_data_o[6] && !fp_error_pin_n_i
      |-> ##[0:4] wake_irq_o) else $error("no wake");
   cover property (alignment_check_fault_o);
   cover property (split_lock_cycle_o && !bus_lock_o);
   cover property (wake_irq_o);
endmodule
bind mfc_ctrl mfc_ctrl_checker mfc_ctrl_checker_i (.*);

/* File: verif/tb.sv */
// Self-checking bench of the feature-control bits.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic [8:0] wd; logic [8:0] rd; logic f, lk, pq, l3;} mfc_row_s;
   logic clk_sys_i = 1'h0, nrst_i = 1'h0, wr_en_i = 1'h0, split_lock_req_i = 1'h0;
   logic global_cache_disable_flag_i = 1'h0, unmasked_fp_error_i = 1'h1;
   logic page_cache_en_i = 1'h1, memory_type_ranges_cache_en_i = 1'h1;
   logic stop_clock_input_n_i = 1'h1, ext_n = 1'h1;
   logic [8:0] wr_data_i = 9'h000, rd_data_o;
   logic alignment_check_fault_o, split_lock_cycle_o, bus_lock_o, l3_cache_en_o;
   logic prefetch_queue_en_o, fp_error_pin_n_o, fp_error_pin_oe_o, stop_clock_state_o, wake_irq_o;
   wire fp_error_pin_n_i = (fp_error_pin_oe_o && !fp_error_pin_n_o) ? 1'h0 : ext_n;
   int mismatches = 0, tests_run = 0, cycles = 0;
   mfc_row_s rows [6] = '{'{9'h000, 9'h008, 1'h0, 1'h1, 1'h1, 1'h1},
      '{9'h001, 9'h009, 1'h1, 1'h0, 1'h1, 1'h1}, '{9'h010, 9'h018, 1'h0, 1'h0, 1'h1, 1'h1},
      '{9'h020, 9'h028, 1'h0, 1'h1, 1'h0, 1'h1}, '{9'h044, 9'h04c, 1'h0, 1'h1, 1'h1, 1'h0},
      '{9'h1ff, 9'h07d, 1'h1, 1'h0, 1'h0, 1'h0}};
   mfc_ctrl mfc_ctrl_i (.*);
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial forever #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 500) begin
         mismatches++;
         stop_test;
      end
   end
   initial begin
      tick(4);
      chk({rd_data_o, prefetch_queue_en_o}, 10'h001);
      nrst_i = 1'h1;
      tick(1);
      chk(rd_data_o, 9'h008);
      $display("Reset test done.");
      foreach (rows[i]) begin
         wr_en_i = 1'h1;
         wr_data_i = rows[i].wd;
         tick(1);
         wr_en_i = 1'h0;
         split_lock_req_i = 1'h1;
         chk(rd_data_o, rows[i].rd);
         tick(1);
         split_lock_req_i = 1'h0;
         chk({alignment_check_fault_o, split_lock_cycle_o}, {rows[i].f, !rows[i].f});
         chk(bus_lock_o, rows[i].lk);
         chk({prefetch_queue_en_o, l3_cache_en_o}, {rows[i].pq, rows[i].l3});
         chk({fp_error_pin_oe_o, fp_error_pin_n_o}, 2'h2);
         $display("Row %0d done.", i);
         tick(1);
      end
      wr_en_i = 1'h1;
      wr_data_i = 9'h001;
      tick(1);
      wr_data_i = 9'h040;
      tick(1);
      wr_en_i = 1'h0;
      global_cache_disable_flag_i = 1'h1;
      chk(rd_data_o, 9'h048);
      tick(2);
      chk(l3_cache_en_o, 1'h0);
      global_cache_disable_flag_i = 1'h0;
      page_cache_en_i = 1'h0;
      tick(2);
      chk(l3_cache_en_o, 1'h0);
      unmasked_fp_error_i = 1'h0;
      page_cache_en_i = 1'h1;
      tick(2);
      chk(l3_cache_en_o, 1'h1);
      stop_clock_input_n_i = 1'h0;
      tick(5);
      chk({stop_clock_state_o, fp_error_pin_oe_o}, 2'h2);
      ext_n = 1'h0;
      for (int k = 0; k < 8 && wake_irq_o !== 1'h1; k++) tick(1);
      chk({wake_irq_o, stop_clock_state_o}, 2'h2);
      stop_clock_input_n_i = 1'h1;
      ext_n = 1'h1;
      tick(5);
      chk({fp_error_pin_oe_o, fp_error_pin_n_o}, 2'h3);
      unmasked_fp_error_i = 1'h1;
      tick(1);
      chk({fp_error_pin_oe_o, fp_error_pin_n_o}, 2'h2);
      $display("Stop clock test done.");
      stop_test;
   end
endmodule
